// *** hdl/adc_trigger_and_compare_control.sv ***
// Local design decisions: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
module adc_trigger_and_compare_control
#(
   parameter int CONV_LEN = 16
) (
   // clock and reset
   input  wire logic                       CLOCK,
   input  wire logic                       RESET_N,
   // avalon-mm slave
   input  wire logic [3:0]                 AVS_ADDRESS,
   input  wire logic                       AVS_READ,
   input  wire logic                       AVS_WRITE,
   input  wire logic [31:0]                AVS_WRITEDATA,
   input  wire logic [3:0]                 AVS_BYTEENABLE,
   output logic      [31:0]                AVS_READDATA,
   output logic                            AVS_WAITREQUEST,
   // pwm events and converter core
   input  wire adc_ctrl_pkg::pwm_events_t  PWM_EVENTS,
   input  wire logic [11:0]                CONV_RESULT,
   output adc_ctrl_pkg::input_route_t      INPUT_ROUTE,
   output logic                            CONV_POWER,
   output logic                            CONV_CLOCK,
   output logic                            CONV_START,
   output logic                            PIN_ANALOG_MODE,
   output logic                            CONV_DONE_IRQ,
   output logic                            BOUND_IRQ
);
   import adc_ctrl_pkg::*;

   // ****************************************************************
   // registers
   // ****************************************************************
   logic [7:0]  main_control;
   logic [7:0]  source_clock;
   logic [7:0]  trigger_config;
   logic [7:0]  start_delay;
   logic [11:0] result;
   logic [11:0] low_bound;
   logic [11:0] high_bound;
   logic        busy;
   logic        ack;
   conv_state_t state;
   logic [7:0]  delay_count;
   logic [7:0]  conv_count;
   logic [6:0]  div_count;
   logic [2:0]  pwm_sync1;
   logic [2:0]  pwm_sync2;
   logic        pwm_prev;
   logic        start_prev;

   // ****************************************************************
   // field decode
   // ****************************************************************
   wire logic       enable      = main_control[POS_ENABLE];
   wire logic       align       = main_control[POS_ALIGN];
   wire logic [3:0] channel     = main_control[3:0];
   wire logic [2:0] source      = source_clock[7:5];
   wire logic [2:0] clk_div     = source_clock[2:0];
   wire logic       trig_pwm    = trigger_config[POS_TRIG_SEL];
   wire logic       delay_en    = trigger_config[POS_DELAY_EN];
   wire logic       pwm_duty    = trigger_config[POS_PWM_SRC];
   wire logic [1:0] cmp_mode    = trigger_config[4:3];
   wire logic [1:0] duty_sel    = trigger_config[1:0];
   wire logic       start_bit   = main_control[POS_START];

   // ****************************************************************
   // alignment helpers
   // ****************************************************************
   function automatic logic [15:0] pack_word(input logic [11:0] v,
                                             input logic        a);
      pack_word = a ? {4'h0, v} : {v, 4'h0};
   endfunction : pack_word

   function automatic logic [11:0] write_byte(input logic [11:0] v,
                                              input logic        a,
                                              input logic        hi,
                                              input logic [7:0]  d);
      logic [15:0] w;
      w = pack_word(v, a);
      if (hi)
         w[15:8] = d;
      else
         w[7:0] = d;
      write_byte = a ? w[11:0] : w[15:4];
   endfunction : write_byte

   // ****************************************************************
   // bus decode
   // ****************************************************************
   wire logic [7:0] wdata  = AVS_WRITEDATA[7:0];
   wire logic [15:0] res_w = pack_word(result, align);
   wire logic [15:0] lo_w  = pack_word(low_bound, align);
   wire logic [15:0] hi_w  = pack_word(high_bound, align);
   logic [7:0] rd_byte;
   always_comb begin
      if (AVS_ADDRESS == ADDR_MAIN_CONTROL)
         rd_byte = {main_control[7], busy, main_control[5:0]};
      else if (AVS_ADDRESS == ADDR_SOURCE_CLOCK)
         rd_byte = source_clock & MASK_SOURCE_CLOCK;
      else if (AVS_ADDRESS == ADDR_TRIGGER_CONFIG)
         rd_byte = trigger_config & MASK_TRIGGER_CFG;
      else if (AVS_ADDRESS == ADDR_START_DELAY)
         rd_byte = start_delay;
      else if (AVS_ADDRESS == ADDR_RESULT_LOW)
         rd_byte = res_w[7:0];
      else if (AVS_ADDRESS == ADDR_RESULT_HIGH)
         rd_byte = res_w[15:8];
      else if (AVS_ADDRESS == ADDR_LOW_BOUND_LOW)
         rd_byte = lo_w[7:0];
      else if (AVS_ADDRESS == ADDR_LOW_BOUND_HIGH)
         rd_byte = lo_w[15:8];
      else if (AVS_ADDRESS == ADDR_HIGH_BOUND_LOW)
         rd_byte = hi_w[7:0];
      else if (AVS_ADDRESS == ADDR_HIGH_BOUND_HIGH)
         rd_byte = hi_w[15:8];
      else
         rd_byte = RESET_BYTE;
   end

   // one wait cycle per access, answer on the second edge
   assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack;

   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N)
         ack <= 1'b0;
      else
         ack <= (AVS_READ | AVS_WRITE) & ~ack;
   end

   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N)
         AVS_READDATA <= 32'h0000_0000;
      else if (AVS_READ & ~ack)
         AVS_READDATA <= {24'h00_0000, rd_byte};
   end

   wire logic commit = AVS_WRITE & ack & AVS_BYTEENABLE[0];

   // ****************************************************************
   // control registers
   // ****************************************************************
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         main_control   <= RESET_BYTE;
         source_clock   <= RESET_BYTE;
         trigger_config <= RESET_BYTE;
         start_delay    <= RESET_BYTE;
      end else if (commit) begin
         if (AVS_ADDRESS == ADDR_MAIN_CONTROL)
            main_control <= wdata;
         else if (AVS_ADDRESS == ADDR_SOURCE_CLOCK)
            source_clock <= wdata & MASK_SOURCE_CLOCK;
         else if (AVS_ADDRESS == ADDR_TRIGGER_CONFIG)
            trigger_config <= wdata & MASK_TRIGGER_CFG;
         else if (AVS_ADDRESS == ADDR_START_DELAY)
            start_delay <= wdata;
      end
   end

   // boundary pairs, written by software in the current layout
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         low_bound  <= 12'h000;
         high_bound <= 12'h000;
      end else if (commit) begin
         if (AVS_ADDRESS == ADDR_LOW_BOUND_LOW)
            low_bound <= write_byte(low_bound, align, 1'b0, wdata);
         else if (AVS_ADDRESS == ADDR_LOW_BOUND_HIGH)
            low_bound <= write_byte(low_bound, align, 1'b1, wdata);
         else if (AVS_ADDRESS == ADDR_HIGH_BOUND_LOW)
            high_bound <= write_byte(high_bound, align, 1'b0, wdata);
         else if (AVS_ADDRESS == ADDR_HIGH_BOUND_HIGH)
            high_bound <= write_byte(high_bound, align, 1'b1, wdata);
      end
   end

   // ****************************************************************
   // input routing and pins
   // ****************************************************************
   wire logic internal_src = source == SRC_AMP || source == SRC_GND_A ||
                             source == SRC_GND_B;
   wire logic chan_valid = ~channel[3] && channel != 4'h1 &&
                           channel != 4'h5;
   assign INPUT_ROUTE.ext_connect = enable & ~internal_src &
                                    chan_valid;
   assign INPUT_ROUTE.channel        = channel;
   assign INPUT_ROUTE.amp_connect    = enable && source == SRC_AMP;
   assign INPUT_ROUTE.ground_connect = enable && (source == SRC_GND_A ||
                                       source == SRC_GND_B);
   assign CONV_POWER      = enable;
   assign PIN_ANALOG_MODE = INPUT_ROUTE.ext_connect;

   // ****************************************************************
   // conversion clock divider
   // ****************************************************************
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N)
         div_count <= 7'h00;
      else
         div_count <= enable ? div_count + 7'h01 : 7'h00;
   end

   wire logic [7:0] div_full = {div_count, 1'b0};
   // code 0 follows the system clock level; others tap counter bit n-1
   assign CONV_CLOCK = enable & (clk_div == 3'h0 ? CLOCK :
                       div_full[clk_div]);

   // ****************************************************************
   // trigger detection
   // ****************************************************************
   wire logic duty_flag = duty_sel == 2'h0 ? pwm_sync2[0] :
                          duty_sel == 2'h1 ? pwm_sync2[1] : 1'b0;
   wire logic pwm_sel   = pwm_duty ? duty_flag : pwm_sync2[2];
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         pwm_sync1  <= 3'h0;
         pwm_sync2  <= 3'h0;
         pwm_prev   <= 1'b0;
         start_prev <= 1'b0;
      end else begin
         pwm_sync1  <= PWM_EVENTS;
         pwm_sync2  <= pwm_sync1;
         pwm_prev   <= pwm_sel;
         start_prev <= start_bit;
      end
   end

   wire logic pwm_rise  = pwm_sel & ~pwm_prev;
   wire logic sw_start  = start_prev & ~start_bit & ~trig_pwm;
   wire logic pwm_go    = pwm_rise & trig_pwm;
   wire logic eff_delay = delay_en && start_delay != 8'h00;

   // ****************************************************************
   // conversion sequencer
   // ****************************************************************
   conv_state_t next_state;
   logic        begin_conv;
   always_comb begin
      next_state = state;
      begin_conv = 1'b0;
      case (state)
         IDLE: begin
            if (enable && (sw_start || (pwm_go && !eff_delay))) begin
               begin_conv = 1'b1;
               next_state = CONVERT;
            end else if (enable && pwm_go)
               next_state = DELAY;
         end
         DELAY: begin
            if (!enable)
               next_state = IDLE;
            else if (delay_count == 8'h01) begin
               begin_conv = 1'b1;
               next_state = CONVERT;
            end
         end
         CONVERT: begin
            if (!enable || conv_count == 8'h01)
               next_state = IDLE;
         end
         default: next_state = IDLE;
      endcase
   end

   wire logic conv_end = state == CONVERT && enable && conv_count == 8'h01;

   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         state       <= IDLE;
         delay_count <= 8'h00;
         conv_count  <= 8'h00;
         busy        <= 1'b0;
      end else begin
         state <= next_state;
         if (state == IDLE)
            delay_count <= start_delay;
         else if (state == DELAY)
            delay_count <= delay_count - 8'h01;
         if (begin_conv)
            conv_count <= 8'(CONV_LEN);
         else if (state == CONVERT)
            conv_count <= conv_count - 8'h01;
         busy <= begin_conv | (busy & enable & ~conv_end);
      end
   end

   assign CONV_START = begin_conv;

   // ****************************************************************
   // result capture and compare
   // ****************************************************************
   wire logic le_low  = CONV_RESULT <= low_bound;
   wire logic ge_high = CONV_RESULT >= high_bound;
   wire logic cmp_hit = cmp_mode == 2'h0 ? ~le_low & ~ge_high :
                        cmp_mode == 2'h1 ? le_low :
                        cmp_mode == 2'h2 ? ge_high :
                        le_low | ge_high;

   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         result        <= 12'h000;
         CONV_DONE_IRQ <= 1'b0;
         BOUND_IRQ     <= 1'b0;
      end else begin
         if (conv_end)
            result <= CONV_RESULT;
         CONV_DONE_IRQ <= conv_end;
         BOUND_IRQ     <= conv_end && source == SRC_AMP &&
                          cmp_hit;
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   a_busy_on_start: assert property (@(posedge CLOCK)
      disable iff (!RESET_N) begin_conv |=> busy)
      else $error("busy not set after start");
   a_busy_clears: assert property (@(posedge CLOCK)
      disable iff (!RESET_N) conv_end |=> !busy && CONV_DONE_IRQ)
      else $error("busy or done wrong at end");
   a_result_stored: assert property (@(posedge CLOCK)
      disable iff (!RESET_N) conv_end |=> result == $past(CONV_RESULT))
      else $error("result not stored");
   a_result_hold: assert property (@(posedge CLOCK)
      disable iff (!RESET_N) !enable |=> $stable(result))
      else $error("result changed while off");
   a_internal_isolate: assert property (@(posedge CLOCK)
      disable iff (!RESET_N) internal_src |-> !INPUT_ROUTE.ext_connect)
      else $error("external input joined to internal");
   a_sw_start_go: assert property (@(posedge CLOCK)
      disable iff (!RESET_N) state == IDLE && enable && sw_start
      |-> CONV_START) else $error("software start missed");
   a_pwm_delay: assert property (@(posedge CLOCK)
      disable iff (!RESET_N) state == IDLE && enable && pwm_go && eff_delay
      && start_delay == 8'h02 |-> ##1 !CONV_START ##1 CONV_START)
      else $error("delay length wrong");
   a_reserved_zero: assert property (@(posedge CLOCK)
      disable iff (!RESET_N) ~|{source_clock[4:3], trigger_config[2]})
      else $error("reserved bit set");
   a_bound_irq_src: assert property (@(posedge CLOCK)
      disable iff (!RESET_N) BOUND_IRQ |-> $past(source) == SRC_AMP)
      else $error("compare irq from wrong source");

endmodule : adc_trigger_and_compare_control

// *** hdl/adc_ctrl_pkg.sv ***
package adc_ctrl_pkg;

   // ****************************************************************
   // register map (word offsets, byte address = 4 * index)
   // ****************************************************************
   localparam logic [3:0] ADDR_MAIN_CONTROL   = 4'h0;
   localparam logic [3:0] ADDR_SOURCE_CLOCK   = 4'h1;
   localparam logic [3:0] ADDR_TRIGGER_CONFIG = 4'h2;
   localparam logic [3:0] ADDR_START_DELAY    = 4'h3;
   localparam logic [3:0] ADDR_RESULT_LOW     = 4'h4;
   localparam logic [3:0] ADDR_RESULT_HIGH    = 4'h5;
   localparam logic [3:0] ADDR_LOW_BOUND_LOW  = 4'h6;
   localparam logic [3:0] ADDR_LOW_BOUND_HIGH = 4'h7;
   localparam logic [3:0] ADDR_HIGH_BOUND_LOW = 4'h8;
   localparam logic [3:0] ADDR_HIGH_BOUND_HIGH= 4'h9;

   // ****************************************************************
   // field positions and reset values
   // ****************************************************************
   localparam int POS_START        = 7;
   localparam int POS_BUSY         = 6;
   localparam int POS_ENABLE       = 5;
   localparam int POS_ALIGN        = 4;
   localparam int POS_TRIG_SEL     = 7;
   localparam int POS_DELAY_EN     = 6;
   localparam int POS_PWM_SRC      = 5;
   localparam logic [7:0] MASK_SOURCE_CLOCK = 8'hE7;
   localparam logic [7:0] MASK_TRIGGER_CFG  = 8'hFB;
   localparam logic [7:0] RESET_BYTE        = 8'h00;
   localparam logic [7:0] CONV_CYCLES       = 8'h10;

   localparam logic [2:0] SRC_AMP    = 3'h1;
   localparam logic [2:0] SRC_GND_A  = 3'h2;
   localparam logic [2:0] SRC_GND_B  = 3'h3;

   typedef enum {IDLE, DELAY, CONVERT} conv_state_t;

   typedef struct packed {
      logic       period_match_flag;
      logic [1:0] duty_match_flag;
   } pwm_events_t;

   typedef struct packed {
      logic       ext_connect;
      logic [3:0] channel;
      logic       amp_connect;
      logic       ground_connect;
   } input_route_t;

endpackage : adc_ctrl_pkg

// *** verif/pwm_event_model.sv ***
`timescale 1ns/1ps
module pwm_event_model
   import adc_ctrl_pkg::*;
(
   // clock and reset
   input  wire logic         CLOCK,
   input  wire logic         RESET_N,
   // requests from the bench
   input  wire logic [2:0]   FIRE,
   input  wire logic [11:0]  LEVEL,
   input  wire logic         POWER,
   // towards the block
   output adc_ctrl_pkg::pwm_events_t EVENTS,
   output logic [11:0]       RESULT
);
   logic       flag [3];
   logic [1:0] age  [3];

   // ****************************************************************
   // match flags: rise on request, drop four cycles later
   // ****************************************************************
   for (genvar i = 0; i < 3; i++) begin : g_flag
      always_ff @(posedge CLOCK or negedge RESET_N) begin
         if (!RESET_N) begin
            flag[i] <= 1'b0;
            age[i]  <= 2'h0;
         end else if (FIRE[i]) begin
            flag[i] <= 1'b1;
            age[i]  <= 2'h3;
         end else if (age[i] != 2'h0) begin
            age[i]  <= age[i] - 2'h1;
         end else begin
            flag[i] <= 1'b0;
         end
      end
   end

   assign EVENTS = {flag[2], flag[1], flag[0]};
   // core output meaningless while switched off
   assign RESULT = POWER ? LEVEL : ~LEVEL;
endmodule : pwm_event_model

// *** verif/tb.sv ***
`timescale 1ns/1ps
module tb;
   import adc_ctrl_pkg::*;
   logic CLOCK = 1'b0, RESET_N = 1'b0, AVS_READ = 1'b0, AVS_WRITE = 1'b0;
   logic [3:0] AVS_ADDRESS = 4'h0, AVS_BYTEENABLE = 4'h1;
   logic [31:0] AVS_WRITEDATA = 32'h0000_0000, AVS_READDATA;
   logic AVS_WAITREQUEST, CONV_POWER, CONV_CLOCK, CONV_START, PIN_ANALOG_MODE;
   logic CONV_DONE_IRQ, BOUND_IRQ, bound_seen = 1'b0, clk_prev = 1'b0;
   logic [2:0] FIRE = 3'h0;
   logic [11:0] LEVEL = 12'h000, CONV_RESULT;
   pwm_events_t PWM_EVENTS;
   input_route_t INPUT_ROUTE;
   int fail_count = 0, checked = 0, cyc = 0, starts = 0, dones = 0;
   int start_cyc = 0, rise_prev = 0, rise_last = 0;

   always #4 CLOCK = ~CLOCK;

   adc_trigger_and_compare_control #(.CONV_LEN(16)) uut (.CLOCK(CLOCK),
      .RESET_N(RESET_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
      .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
      .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
      .AVS_WAITREQUEST(AVS_WAITREQUEST), .PWM_EVENTS(PWM_EVENTS),
      .CONV_RESULT(CONV_RESULT), .INPUT_ROUTE(INPUT_ROUTE),
      .CONV_POWER(CONV_POWER), .CONV_CLOCK(CONV_CLOCK),
      .CONV_START(CONV_START), .PIN_ANALOG_MODE(PIN_ANALOG_MODE),
      .CONV_DONE_IRQ(CONV_DONE_IRQ), .BOUND_IRQ(BOUND_IRQ));

   pwm_event_model pwm (.CLOCK(CLOCK), .RESET_N(RESET_N), .FIRE(FIRE),
      .LEVEL(LEVEL), .POWER(CONV_POWER), .EVENTS(PWM_EVENTS),
      .RESULT(CONV_RESULT));

   // ****************************************************************
   // monitor, sampled mid-cycle
   // ****************************************************************
   always @(negedge CLOCK) begin
      if (CONV_START === 1'b1) begin
         starts++;
         start_cyc = cyc;
      end
      if (CONV_DONE_IRQ === 1'b1) begin
         dones++;
         bound_seen = BOUND_IRQ;
      end
      if (CONV_CLOCK === 1'b1 && clk_prev !== 1'b1) begin
         rise_prev = rise_last;
         rise_last = cyc;
      end
      clk_prev = CONV_CLOCK;
      cyc++;
   end

   // ****************************************************************
   // shared tasks
   // ****************************************************************
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic bus(input logic wr, input logic [3:0] a,
                      input logic [7:0] d, input logic [3:0] be,
                      output logic [7:0] q);
      @(posedge CLOCK);
      AVS_ADDRESS    <= a;
      AVS_WRITEDATA  <= {24'h00_0000, d};
      AVS_BYTEENABLE <= be;
      AVS_WRITE      <= wr;
      AVS_READ       <= !wr;
      do begin
         @(posedge CLOCK);
      end while (AVS_WAITREQUEST !== 1'b0);
      q = AVS_READDATA[7:0];
      AVS_WRITE <= 1'b0;
      AVS_READ  <= 1'b0;
   endtask : bus

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, a, d, 4'h1, q);
   endtask : wr

   task automatic rdc(input logic [3:0] a, input logic [7:0] e);
      logic [7:0] q;
      bus(1'b0, a, 8'h00, 4'h1, q);
      chk({4'h0, q}, {4'h0, e});
   endtask : rdc

   task automatic conv(input logic [7:0] m, input logic [11:0] r);
      int d0, n;
      LEVEL <= r;
      d0 = dones;
      wr(ADDR_MAIN_CONTROL, m | 8'h80);
      wr(ADDR_MAIN_CONTROL, m);
      rdc(ADDR_MAIN_CONTROL, {2'b01, m[5:0]});
      n = 0;
      while (dones == d0 && n < 200) begin
         @(posedge CLOCK);
         n++;
      end
      chk(12'(dones - d0), 12'h001);
   endtask : conv

   task automatic fire(input logic [2:0] f, input int e);
      int s0;
      s0 = starts;
      @(posedge CLOCK);
      FIRE <= f;
      @(posedge CLOCK);
      FIRE <= 3'h0;
      repeat (40) @(posedge CLOCK);
      chk(12'(starts - s0), 12'(e));
   endtask : fire

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_regs;
      logic [7:0] q;
      for (int a = 0; a < 10; a++) rdc(4'(a), 8'h00);
      rdc(4'hF, 8'h00);
      bus(1'b1, ADDR_START_DELAY, 8'h55, 4'h0, q);
      rdc(ADDR_START_DELAY, 8'h00);
      wr(ADDR_SOURCE_CLOCK, 8'hFF);
      rdc(ADDR_SOURCE_CLOCK, 8'hE7);
      wr(ADDR_TRIGGER_CONFIG, 8'hFF);
      rdc(ADDR_TRIGGER_CONFIG, 8'hFB);
      wr(ADDR_TRIGGER_CONFIG, 8'h00);
      wr(ADDR_SOURCE_CLOCK, 8'h00);
      wr(ADDR_MAIN_CONTROL, 8'h40);
      rdc(ADDR_MAIN_CONTROL, 8'h00);
      @(negedge CLOCK);
      chk({11'h000, CONV_POWER}, 12'h000);
   endtask : t_regs

   task automatic t_route;
      logic e;
      wr(ADDR_MAIN_CONTROL, 8'h22);
      for (int s = 0; s < 8; s++) begin
         wr(ADDR_SOURCE_CLOCK, {3'(s), 5'h00});
         @(negedge CLOCK);
         e = (s == 0 || s > 3);
         chk({11'h000, INPUT_ROUTE.ext_connect}, {11'h000, e});
         chk({11'h000, PIN_ANALOG_MODE}, {11'h000, e});
         chk({11'h000, INPUT_ROUTE.amp_connect}, 12'(s == 1));
         chk({11'h000, INPUT_ROUTE.ground_connect}, 12'(s == 2 || s == 3));
         if (e) chk({8'h00, INPUT_ROUTE.channel}, 12'h002);
      end
      wr(ADDR_SOURCE_CLOCK, 8'h00);
   endtask : t_route

   task automatic t_soft;
      chk({11'h000, CONV_POWER}, 12'h001);
      wr(ADDR_LOW_BOUND_HIGH, 8'h12);
      conv(8'h30, 12'hABC);
      rdc(ADDR_MAIN_CONTROL, 8'h30);
      rdc(ADDR_RESULT_LOW, 8'hBC);
      rdc(ADDR_RESULT_HIGH, 8'h0A);
      wr(ADDR_MAIN_CONTROL, 8'h20);
      rdc(ADDR_RESULT_LOW, 8'hC0);
      rdc(ADDR_RESULT_HIGH, 8'hAB);
      wr(ADDR_MAIN_CONTROL, 8'h00);
      LEVEL <= 12'h123;
      @(negedge CLOCK);
      chk({11'h000, CONV_POWER}, 12'h000);
      rdc(ADDR_RESULT_HIGH, 8'hAB);
      rdc(ADDR_LOW_BOUND_HIGH, 8'h12);
   endtask : t_soft

   task automatic t_pwm;
      int s0, f, lat [2];
      wr(ADDR_MAIN_CONTROL, 8'h20);
      wr(ADDR_TRIGGER_CONFIG, 8'hC0);
      for (int i = 0; i < 2; i++) begin
         wr(ADDR_START_DELAY, 8'(2 + 20 * i));
         s0 = starts;
         @(posedge CLOCK);
         FIRE <= 3'h4;
         f = cyc;
         @(posedge CLOCK);
         FIRE <= 3'h0;
         repeat (70) @(posedge CLOCK);
         chk(12'(starts - s0), 12'h001);
         lat[i] = start_cyc - f;
      end
      chk(12'(lat[1] - lat[0]), 12'h014);
      wr(ADDR_START_DELAY, 8'h00);
      wr(ADDR_TRIGGER_CONFIG, 8'h21);
      fire(3'h2, 0);
      wr(ADDR_TRIGGER_CONFIG, 8'hA1);
      fire(3'h4, 0);
      fire(3'h1, 0);
      fire(3'h2, 1);
      wr(ADDR_TRIGGER_CONFIG, 8'hA2);
      fire(3'h3, 0);
      wr(ADDR_TRIGGER_CONFIG, 8'hA0);
      fire(3'h1, 1);
      wr(ADDR_TRIGGER_CONFIG, 8'h80);
      fire(3'h4, 1);
   endtask : t_pwm

   task automatic t_cmp;
      logic [11:0] v [4] = '{12'h100, 12'h400, 12'h800, 12'h900};
      logic lo, hi, e;
      wr(ADDR_TRIGGER_CONFIG, 8'h00);
      wr(ADDR_MAIN_CONTROL, 8'h30);
      wr(ADDR_LOW_BOUND_HIGH, 8'h01);
      wr(ADDR_HIGH_BOUND_HIGH, 8'h08);
      wr(ADDR_LOW_BOUND_LOW, 8'h00);
      wr(ADDR_HIGH_BOUND_LOW, 8'h00);
      wr(ADDR_SOURCE_CLOCK, 8'h20);
      for (int c = 0; c < 4; c++) begin
         wr(ADDR_TRIGGER_CONFIG, {3'h0, 2'(c), 3'h0});
         for (int i = 0; i < 4; i++) begin
            conv(8'h30, v[i]);
            lo = (v[i] <= 12'h100);
            hi = (v[i] >= 12'h800);
            e = (c == 0) ? (!lo && !hi) : (c == 1) ? lo : (c == 2) ? hi : lo | hi;
            chk({11'h000, bound_seen}, {11'h000, e});
         end
      end
      wr(ADDR_SOURCE_CLOCK, 8'h00);
      conv(8'h30, 12'h900);
      chk({11'h000, bound_seen}, 12'h000);
   endtask : t_cmp

   task automatic t_div;
      for (int k = 1; k < 8; k++) begin
         wr(ADDR_SOURCE_CLOCK, 8'(k));
         repeat ((3 << k) + 4) @(posedge CLOCK);
         chk(12'(rise_last - rise_prev), 12'(1 << k));
      end
   endtask : t_div

   task automatic results;
      if (fail_count == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : results

   initial begin
      repeat (16) @(posedge CLOCK);
      RESET_N <= 1'b1;
      t_regs;
      t_route;
      t_soft;
      t_pwm;
      t_cmp;
      t_div;
      results;
   end

   initial begin
      #400000;
      fail_count++;
      results;
   end
endmodule : tb
